// ---- uart_fifo_reset_break_ctrl.sv ----
// queue level, queue flush strobes, soft reset and break mirror registers
//
// Contract
// - read-only five-bit receive queue count, resets zero
// - strobe bit 2 equals queue control tx flush
// - tx flush empties queue, clears itself
// - strobe bit 1 equals queue control rx flush
// - rx flush empties queue, clears itself
// - strobe bit 0: reset asserts at once, releases clocked
// - soft reset clears bus and serial domains
// - mirror bit 0 shares line control break bit
// - break holds loopback data at spacing zero
// - without loopback, output low until break cleared
`timescale 1ns/10ps
module uart_fifo_reset_break_ctrl #(
  parameter int LEVEL_WIDTH = uart_flush_pkg::RX_LEVEL_WIDTH
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [31:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [LEVEL_WIDTH-1:0] rxLevelIn,
  input  wire logic        queueCtrlWrite,
  input  wire logic        queueCtrlTxFlush,
  input  wire logic        queueCtrlRxFlush,
  input  wire logic        lineCtrlWrite,
  input  wire logic        lineCtrlBreak,
  input  wire logic        loopbackEn,
  input  wire logic        serialTxData,
  output logic [LEVEL_WIDTH-1:0] rxFifoLevel,
  output logic             txQueueFlush,
  output logic             rxQueueFlush,
  output logic             busDomainReset,
  output logic             serialDomainReset,
  output logic             breakState,
  output logic             serialOut,
  output logic             loopbackData
);
  typedef struct packed {
    logic [LEVEL_WIDTH-1:0] rxLevel;
    logic                   breakBit;
    logic                   txOut;
    logic                   loopOut;
    logic                   txFlush;
    logic                   rxFlush;
    logic                   softReq;
    logic                   rdValid;
    logic [31:0]            rdData;
  } ctrl_s;

  ctrl_s s_reg;
  ctrl_s s_next;
  logic  ctrlReset;
  logic  wrHit;
  logic  hitLevel;
  logic  hitStrobe;
  logic  hitBreak;

  initial
  begin
    if (LEVEL_WIDTH != uart_flush_pkg::RX_LEVEL_WIDTH)
      $error("receive level field is five bits wide");
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign hitLevel  = (address == uart_flush_pkg::RX_FIFO_LEVEL_ADDR);
  assign hitStrobe = (address == uart_flush_pkg::SOFT_RESET_STROBES_ADDR);
  assign hitBreak  = (address == uart_flush_pkg::BREAK_MIRROR_CTRL_ADDR);
  // every field sits in the low byte, so only lane 0 commits a write
  assign wrHit     = write & byteenable[0];

  // reads take one wait cycle so that read data always comes from a flop
  assign waitrequest = read & ~s_reg.rdValid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next         = s_reg;
    s_next.rdValid = read & ~s_reg.rdValid;
    s_next.txFlush = 1'b0;
    s_next.rxFlush = 1'b0;
    s_next.softReq = 1'b0;
    s_next.rxLevel = rxLevelIn;
    if (wrHit && hitStrobe)
    begin
      s_next.txFlush = writedata[uart_flush_pkg::TX_FLUSH_BIT];
      s_next.rxFlush = writedata[uart_flush_pkg::RX_FLUSH_BIT];
      s_next.softReq = writedata[uart_flush_pkg::SOFT_RESET_BIT];
    end
    if (queueCtrlWrite)
    begin
      s_next.txFlush = s_next.txFlush | queueCtrlTxFlush;
      s_next.rxFlush = s_next.rxFlush | queueCtrlRxFlush;
    end
    // line control and the mirror address write the same flop
    if (lineCtrlWrite)
      s_next.breakBit = lineCtrlBreak;
    if (wrHit && hitBreak)
      s_next.breakBit = writedata[uart_flush_pkg::BREAK_MIRROR_BIT];
    if (ctrlReset)
    begin
      // the soft reset restores line control, so break drops too
      s_next.breakBit = uart_flush_pkg::BREAK_RESET;
      s_next.txFlush  = 1'b0;
      s_next.rxFlush  = 1'b0;
    end
    if (s_next.rxFlush || ctrlReset)
      s_next.rxLevel = '0;
    s_next.rdData = uart_flush_pkg::UNMAPPED_VALUE;
    if (hitLevel)
      s_next.rdData[LEVEL_WIDTH-1:0] = s_reg.rxLevel;
    else if (hitBreak)
      s_next.rdData[uart_flush_pkg::BREAK_MIRROR_BIT] = s_reg.breakBit;
    if (!s_next.rdValid)
      s_next.rdData = s_reg.rdData;
    // loopback keeps the pin idle and sends break to the inner path
    s_next.loopOut = s_next.breakBit ? uart_flush_pkg::LINE_SPACING : serialTxData;
    if (loopbackEn)
      s_next.txOut = uart_flush_pkg::LINE_IDLE;
    else
      s_next.txOut = s_next.loopOut;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_reg         <= '0;
      s_reg.txOut   <= uart_flush_pkg::LINE_IDLE;
      s_reg.loopOut <= uart_flush_pkg::LINE_IDLE;
      s_reg.rdData  <= uart_flush_pkg::REG_RESET_VALUE;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // soft reset release
  // ----------------------------------------------------------------
  reset_release_sync #(
    .STAGES (uart_flush_pkg::RELEASE_STAGES)
  ) u_release (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .assertReq (s_reg.softReq),
    .resetOut  (ctrlReset)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // one clock here, so both domains take the same stretched reset
  assign busDomainReset    = ctrlReset;
  assign serialDomainReset = ctrlReset;
  assign readdata          = s_reg.rdData;
  assign rxFifoLevel       = s_reg.rxLevel;
  assign txQueueFlush      = s_reg.txFlush;
  assign rxQueueFlush      = s_reg.rxFlush;
  assign breakState        = s_reg.breakBit;
  assign serialOut         = s_reg.txOut;
  assign loopbackData      = s_reg.loopOut;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_level_track;
    @(posedge clk_sys) disable iff (reset)
      !s_next.rxFlush && !ctrlReset |=> rxFifoLevel == $past(rxLevelIn);
  endproperty
  a_level_track: assert property (p_level_track)
    else $error("receive level does not follow the queue count");

  property p_level_read;
    @(posedge clk_sys) disable iff (reset)
      read && !waitrequest && hitLevel |-> readdata == {27'h0000000, $past(rxFifoLevel)};
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("level read returns a wrong value");

  property p_tx_flush;
    @(posedge clk_sys) disable iff (reset || ctrlReset)
      (wrHit && hitStrobe && writedata[uart_flush_pkg::TX_FLUSH_BIT])
      || (queueCtrlWrite && queueCtrlTxFlush) |=> txQueueFlush || ctrlReset;
  endproperty
  a_tx_flush: assert property (p_tx_flush)
    else $error("transmit flush strobe missing");

  property p_tx_self_clear;
    @(posedge clk_sys) disable iff (reset)
      txQueueFlush && !(wrHit && hitStrobe) && !queueCtrlWrite |=> !txQueueFlush;
  endproperty
  a_tx_self_clear: assert property (p_tx_self_clear)
    else $error("transmit flush did not clear itself");

  property p_rx_flush;
    @(posedge clk_sys) disable iff (reset || ctrlReset)
      (wrHit && hitStrobe && writedata[uart_flush_pkg::RX_FLUSH_BIT])
      || (queueCtrlWrite && queueCtrlRxFlush) |=> rxQueueFlush || ctrlReset;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("receive flush strobe missing");

  property p_rx_empty;
    @(posedge clk_sys) disable iff (reset)
      rxQueueFlush |-> rxFifoLevel == '0;
  endproperty
  a_rx_empty: assert property (p_rx_empty)
    else $error("receive level not zero during flush");

  property p_rx_self_clear;
    @(posedge clk_sys) disable iff (reset)
      rxQueueFlush && !(wrHit && hitStrobe) && !queueCtrlWrite |=> !rxQueueFlush;
  endproperty
  a_rx_self_clear: assert property (p_rx_self_clear)
    else $error("receive flush did not clear itself");

  property p_soft_reset;
    @(posedge clk_sys) disable iff (reset)
      wrHit && hitStrobe && writedata[uart_flush_pkg::SOFT_RESET_BIT]
      |=> busDomainReset[*3];
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset not held for its release time");

  property p_soft_release;
    @(posedge clk_sys) disable iff (reset)
      busDomainReset && !s_reg.softReq ##1 !s_reg.softReq ##1 !s_reg.softReq
      |-> !busDomainReset;
  endproperty
  a_soft_release: assert property (p_soft_release)
    else $error("soft reset not released after two edges");

  property p_both_domains;
    @(posedge clk_sys) disable iff (reset)
      busDomainReset |-> serialDomainReset ##1 !breakState;
  endproperty
  a_both_domains: assert property (p_both_domains)
    else $error("soft reset did not clear both domains");

  property p_break_mirror;
    @(posedge clk_sys) disable iff (reset)
      wrHit && hitBreak && !ctrlReset
      |=> breakState == $past(writedata[uart_flush_pkg::BREAK_MIRROR_BIT]);
  endproperty
  a_break_mirror: assert property (p_break_mirror)
    else $error("break mirror write not taken");

  property p_break_spacing;
    @(posedge clk_sys) disable iff (reset)
      breakState |-> loopbackData == uart_flush_pkg::LINE_SPACING;
  endproperty
  a_break_spacing: assert property (p_break_spacing)
    else $error("break does not force spacing");

  property p_break_pin;
    @(posedge clk_sys) disable iff (reset)
      breakState && !loopbackEn |=> !serialOut || !breakState;
  endproperty
  a_break_pin: assert property (p_break_pin)
    else $error("serial output not low during break");

  property p_strobe_read_zero;
    @(posedge clk_sys) disable iff (reset)
      read && !waitrequest && hitStrobe |-> readdata == uart_flush_pkg::UNMAPPED_VALUE;
  endproperty
  a_strobe_read_zero: assert property (p_strobe_read_zero)
    else $error("strobe register read not zero");

  c_tx_flush: cover property (@(posedge clk_sys) disable iff (reset) txQueueFlush);
  c_rx_flush: cover property (@(posedge clk_sys) disable iff (reset) rxQueueFlush);
  c_soft_reset: cover property (@(posedge clk_sys) disable iff (reset) $rose(busDomainReset));
  c_break: cover property (@(posedge clk_sys) disable iff (reset)
    breakState && !loopbackEn ##1 !serialOut);
endmodule

// ---- uart_flush_pkg.sv ----
// constants for the queue flush, soft reset and break mirror block
package uart_flush_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] RX_FIFO_LEVEL_ADDR      = 32'h50020084;
  localparam logic [31:0] SOFT_RESET_STROBES_ADDR = 32'h50020088;
  localparam logic [31:0] BREAK_MIRROR_CTRL_ADDR  = 32'h50020090;
  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int RX_LEVEL_WIDTH     = 5;
  localparam int TX_FLUSH_BIT       = 2;
  localparam int RX_FLUSH_BIT       = 1;
  localparam int SOFT_RESET_BIT     = 0;
  localparam int BREAK_MIRROR_BIT   = 0;
  localparam int LINE_CTRL_BREAK    = 6;
  localparam int MODEM_CTRL_LOOP    = 4;
  localparam int DATA_WIDTH         = 32;
  localparam int BYTE_LANES         = 4;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_RESET_VALUE = 32'h00000000;
  localparam logic [31:0] UNMAPPED_VALUE  = 32'h00000000;
  localparam logic        BREAK_RESET     = 1'b0;
  localparam logic        LINE_IDLE       = 1'b1;
  localparam logic        LINE_SPACING    = 1'b0;
  localparam int          RELEASE_STAGES  = 2;
endpackage

// ---- reset_release_sync.sv ----
// soft reset stretcher: immediate assertion, clocked release
`timescale 1ns/10ps
module reset_release_sync #(
  parameter int STAGES = uart_flush_pkg::RELEASE_STAGES
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic assertReq,
  output logic      resetOut
);
  typedef struct packed {
    logic [STAGES-1:0] stage;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;

  initial
  begin
    if (STAGES < 2)
      $error("reset_release_sync needs at least two stages");
  end

  // ----------------------------------------------------------------
  // release chain
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    if (assertReq)
      s_next.stage = '1;
    else
      s_next.stage = {s_reg.stage[STAGES-2:0], 1'b0};
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // request reaches the output without waiting for an edge
  assign resetOut = assertReq | s_reg.stage[STAGES-1];
endmodule

// ---- uart_line_watch.sv ----
// far-end serial receiver model that flags a break seen on the line
`timescale 1ns/10ps
module uart_line_watch #(
  parameter int BREAK_CYCLES = 10
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic lineIn,
  output logic      breakSeen
);
  // ----------------------------------------------------------------
  // spacing run counter
  // ----------------------------------------------------------------
  int lowCount;
  // only a long unbroken spacing run counts, so a data zero never looks like a break
  always_ff @(posedge clk_sys)
  begin
    if (reset || lineIn)
      lowCount <= 0;
    else if (lowCount < BREAK_CYCLES)
      lowCount <= lowCount + 1;
  end
  assign breakSeen = (lowCount >= BREAK_CYCLES);
endmodule

// ---- uart_fifo_reset_break_ctrl_bench.sv ----
// self-checking bench for the queue flush, soft reset and break mirror block
`timescale 1ns/10ps
module uart_fifo_reset_break_ctrl_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] address = 32'h00000000;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [4:0]  rxLevelIn = 5'h00;
  logic        queueCtrlWrite = 1'b0;
  logic        queueCtrlTxFlush = 1'b0;
  logic        queueCtrlRxFlush = 1'b0;
  logic        lineCtrlWrite = 1'b0;
  logic        lineCtrlBreak = 1'b0;
  logic        loopbackEn = 1'b0;
  logic        serialTxData = 1'b1;
  logic [4:0]  rxFifoLevel;
  logic        txQueueFlush;
  logic        rxQueueFlush;
  logic        busDomainReset;
  logic        serialDomainReset;
  logic        breakState;
  logic        serialOut;
  logic        loopbackData;
  logic        breakSeen;
  logic [31:0] seed = 32'h5827B574;
  logic [2:0]  fd [4] = '{3'h4, 3'h2, 3'h6, 3'h6};
  logic [2:0]  ex;
  logic [4:0]  lvl;
  int          fails = 0;
  int          checkCount = 0;
  int          i;

  uart_fifo_reset_break_ctrl dut (.clk_sys(clk_sys), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .rxLevelIn(rxLevelIn),
    .queueCtrlWrite(queueCtrlWrite), .queueCtrlTxFlush(queueCtrlTxFlush),
    .queueCtrlRxFlush(queueCtrlRxFlush), .lineCtrlWrite(lineCtrlWrite),
    .lineCtrlBreak(lineCtrlBreak), .loopbackEn(loopbackEn), .serialTxData(serialTxData),
    .rxFifoLevel(rxFifoLevel), .txQueueFlush(txQueueFlush), .rxQueueFlush(rxQueueFlush),
    .busDomainReset(busDomainReset), .serialDomainReset(serialDomainReset),
    .breakState(breakState), .serialOut(serialOut), .loopbackData(loopbackData));

  uart_line_watch far (.clk_sys(clk_sys), .reset(reset), .lineIn(serialOut),
    .breakSeen(breakSeen));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus cycle; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk_sys);
    write <= wr;
    read <= ~wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    // no local limit: only the watchdog ends a wait that never answers
    do
    begin
      @(posedge clk_sys);
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hF, q);
    chk(q, e);
  endtask

  // queue control register write seen from the side port
  task automatic qc(input logic t, input logic r);
    @(posedge clk_sys);
    queueCtrlWrite <= 1'b1;
    queueCtrlTxFlush <= t;
    queueCtrlRxFlush <= r;
    @(posedge clk_sys);
    queueCtrlWrite <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    test_done;
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rd(uart_flush_pkg::RX_FIFO_LEVEL_ADDR, 32'h00000000);
    rd(uart_flush_pkg::SOFT_RESET_STROBES_ADDR, 32'h00000000);
    rd(uart_flush_pkg::BREAK_MIRROR_CTRL_ADDR, 32'h00000000);
    rd(32'h5002008C, 32'h00000000);
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      lvl = (i == 0) ? 5'h1F : seed[4:0];
      rxLevelIn <= lvl;
      serialTxData <= seed[5];
      repeat (2) @(posedge clk_sys);
      #1;
      chk(serialOut, seed[5]);
      rd(uart_flush_pkg::RX_FIFO_LEVEL_ADDR, {27'h0, lvl});
    end
    rxLevelIn <= 5'h13;
    // idle line, so the far end cannot see a break before one is sent
    serialTxData <= 1'b1;
    // last pass arrives through the side port, fourth is masked by byteenable
    for (i = 0; i < 5; i++)
    begin
      if (i < 4)
        wr(uart_flush_pkg::SOFT_RESET_STROBES_ADDR, {29'h0, fd[i]}, (i == 3) ? 4'hE : 4'hF);
      else
        qc(1'b1, 1'b1);
      ex = (i == 3) ? 3'h0 : (i == 4) ? 3'h6 : fd[i];
      #1;
      chk(txQueueFlush, ex[2]);
      chk(rxQueueFlush, ex[1]);
      if (ex[1])
        chk(rxFifoLevel, 32'h00000000);
      @(posedge clk_sys);
      #1;
      chk({txQueueFlush, rxQueueFlush}, 32'h00000000);
    end
    chk(breakSeen, 32'h00000000);
    wr(uart_flush_pkg::BREAK_MIRROR_CTRL_ADDR, 32'hFFFFFFFF, 4'hF);
    #1;
    chk(breakState, 32'h00000001);
    chk(serialOut, 32'h00000000);
    repeat (12) @(posedge clk_sys);
    #1;
    chk(breakSeen, 32'h00000001);
    rd(uart_flush_pkg::BREAK_MIRROR_CTRL_ADDR, 32'h00000001);
    loopbackEn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({serialOut, loopbackData}, 32'h00000002);
    @(posedge clk_sys);
    loopbackEn <= 1'b0;
    lineCtrlWrite <= 1'b1;
    @(posedge clk_sys);
    lineCtrlWrite <= 1'b0;
    rd(uart_flush_pkg::BREAK_MIRROR_CTRL_ADDR, 32'h00000000);
    lineCtrlBreak <= 1'b1;
    lineCtrlWrite <= 1'b1;
    @(posedge clk_sys);
    lineCtrlWrite <= 1'b0;
    rd(uart_flush_pkg::BREAK_MIRROR_CTRL_ADDR, 32'h00000001);
    wr(uart_flush_pkg::SOFT_RESET_STROBES_ADDR, 32'h00000001, 4'hF);
    for (i = 0; i < 4; i++)
    begin
      #1;
      chk(busDomainReset, i < 3);
      chk(serialDomainReset, i < 3);
      @(posedge clk_sys);
    end
    rd(uart_flush_pkg::BREAK_MIRROR_CTRL_ADDR, 32'h00000000);
    test_done;
  end
endmodule
